/* File: hdl/bridge_window_pkg.sv */
// Purpose: shared constants and carriers for the bridge window registers
// Assumes: dword offsets as byte addresses of the type 1 header
// Notes: single-bit field positions and the window, pointer and interrupt reset values live here
package bridge_window_pkg;
  // ****************************************
  // register offsets
  // ****************************************
  localparam logic [7:0] OFF_SEC_IO = 8'h1c;
  localparam logic [7:0] OFF_MEM_WIN = 8'h20;
  localparam logic [7:0] OFF_PREF_WIN = 8'h24;
  localparam logic [7:0] OFF_PREF_UP_BASE = 8'h28;
  localparam logic [7:0] OFF_PREF_UP_LIM = 8'h2c;
  localparam logic [7:0] OFF_IO_UPPER = 8'h30;
  localparam logic [7:0] OFF_CAP_PTR = 8'h34;
  localparam logic [7:0] OFF_ROM_BASE = 8'h38;
  localparam logic [7:0] OFF_BRIDGE_CTRL = 8'h3c;
  // ****************************************
  // field positions
  // ****************************************
  localparam int SEC_MDPE_BIT = 24;
  localparam int SEC_RSE_BIT = 30;
  localparam int SEC_DPE_BIT = 31;
  localparam int PCAP_BASE_BIT = 0;
  localparam int PCAP_LIM_BIT = 16;
  localparam int BC_PERR_BIT = 16;
  localparam int BC_SERR_BIT = 17;
  localparam int BC_ISA_BIT = 18;
  // ****************************************
  // reset and fixed values
  // ****************************************
  localparam logic [3:0] IO_CAP_32 = 4'h1;
  localparam logic [3:0] IO_BASE_RST = 4'hf;
  localparam logic [3:0] IO_LIM_RST = 4'h0;
  localparam logic [11:0] MEM_BASE_RST = 12'hfff;
  localparam logic [11:0] MEM_LIM_RST = 12'h000;
  localparam logic [7:0] CAP_PTR_RST = 8'h40;
  localparam logic [7:0] INT_LINE_RST = 8'h00;
  localparam logic [7:0] INT_PIN_RST = 8'h01;
  localparam logic [19:0] MEM_LOW_ONES = 20'hfffff;
  localparam logic [11:0] IO_LOW_ONES = 12'hfff;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [3:0] be;
    logic [31:0] wdata;
  } cfg_req_t;

  typedef struct packed {
    logic wr;
    logic [7:0] addr;
    logic [31:0] data;
  } load_req_t;

  typedef struct packed {
    logic poison_cpl;
    logic poison_wr_fwd;
    logic poison_rx;
    logic err_fatal_nf;
    logic err_cor;
  } sec_event_t;
endpackage

/* File: hdl/bridge_window_decode_regs.sv */
// Purpose: type 1 bridge secondary status, windows and bridge control low half
// Assumes: one configuration access port and one initialization load port
// Notes: decode outputs are combinational, read data and event pulses are flopped
// How it works
// - parity enable lets poisoned traffic set flag
// - parity enable clear never sets that flag
// - fatal or nonfatal message sets received flag
// - poisoned tlp received always sets detected parity flag
// - abort status bits always read zero
// - forward down inside valid non-prefetch window
// - forward up outside both memory windows
// - non-prefetch window 1 MB granular fields
// - prefetch window same 1 MB layout
// - prefetch capability bits read-only, load only
// - upper base writable only with 64-bit capability
// - upper limit writable only with 64-bit capability
// - io upper halves hold address bits 31:16
// - capability pointer fixed byte, default 40h
// - expansion rom register reads zero
// - interrupt line is plain scratch byte
// - interrupt pin only 00h or 01h
// - bridge bit 16 enables parity flag
// - bridge bit 17 gates error forwarding
// - isa enable punches holes below 64 KB
// - inverted io window forwards everything up
// - io capability fields read 1h
`timescale 1ns/1ps
module bridge_window_decode_regs (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire bridge_window_pkg::cfg_req_t cfg,
  output logic [31:0] cfg_rdata,
  output logic cfg_rvalid,
  input wire bridge_window_pkg::load_req_t load,
  input wire bridge_window_pkg::sec_event_t sec_ev,
  input wire logic cmd_serr_en,
  input wire logic [63:0] pri_addr,
  input wire logic pri_io,
  output logic pri_mem_hit,
  output logic pri_io_hit,
  input wire logic [63:0] sec_addr,
  input wire logic sec_io,
  output logic sec_mem_up,
  output logic sec_io_up,
  output logic err_fwd_up,
  output logic sig_serr_set
);
  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [31:0] merge_bytes(input logic [31:0] old,
                                              input logic [31:0] wd,
                                              input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic in_window(input logic [63:0] a, input logic [63:0] lo,
                                     input logic [63:0] hi);
    return (lo <= hi) && (a >= lo) && (a <= hi);
  endfunction

  // ****************************************
  // state
  // ****************************************
  logic sec_mdpe;
  logic sec_rse;
  logic sec_dpe;
  logic [3:0] io_base;
  logic [3:0] io_lim;
  logic [11:0] mem_base;
  logic [11:0] mem_lim;
  logic pcap_base;
  logic pcap_lim;
  logic [11:0] pref_window_low_bound;
  logic [11:0] pref_window_high_bound;
  logic [31:0] pref_low_bound_upper_word;
  logic [31:0] pref_high_bound_upper_word;
  logic [15:0] io_up_base;
  logic [15:0] io_up_lim;
  logic [7:0] cap_ptr;
  logic [7:0] int_line;
  logic int_pin_a;
  logic bc_perr;
  logic bc_serr;
  logic bc_isa;
  logic [7:0] rd_off;

  // ****************************************
  // read view
  // ****************************************
  function automatic logic [31:0] read_word(input logic [7:0] off);
    logic [31:0] r;
    r = 32'h0000_0000;
    case (off)
      bridge_window_pkg::OFF_SEC_IO: begin
        r[3:0] = bridge_window_pkg::IO_CAP_32;
        r[7:4] = io_base;
        r[11:8] = bridge_window_pkg::IO_CAP_32;
        r[15:12] = io_lim;
        // abort bits 29:27 stay zero: the port never starts requests
        r[bridge_window_pkg::SEC_MDPE_BIT] = sec_mdpe;
        r[bridge_window_pkg::SEC_RSE_BIT] = sec_rse;
        r[bridge_window_pkg::SEC_DPE_BIT] = sec_dpe;
      end
      bridge_window_pkg::OFF_MEM_WIN: begin
        r[15:4] = mem_base;
        r[31:20] = mem_lim;
      end
      bridge_window_pkg::OFF_PREF_WIN: begin
        r[bridge_window_pkg::PCAP_BASE_BIT] = pcap_base;
        r[15:4] = pref_window_low_bound;
        r[bridge_window_pkg::PCAP_LIM_BIT] = pcap_lim;
        r[31:20] = pref_window_high_bound;
      end
      bridge_window_pkg::OFF_PREF_UP_BASE: begin
        r = pcap_base ? pref_low_bound_upper_word : 32'h0000_0000;
      end
      bridge_window_pkg::OFF_PREF_UP_LIM: begin
        r = pcap_lim ? pref_high_bound_upper_word : 32'h0000_0000;
      end
      bridge_window_pkg::OFF_IO_UPPER: begin
        r = {io_up_lim, io_up_base};
      end
      bridge_window_pkg::OFF_CAP_PTR: begin
        r[7:0] = cap_ptr;
      end
      bridge_window_pkg::OFF_ROM_BASE: begin
        r = 32'h0000_0000;
      end
      bridge_window_pkg::OFF_BRIDGE_CTRL: begin
        r[7:0] = int_line;
        r[15:8] = {7'h00, int_pin_a};
        r[bridge_window_pkg::BC_PERR_BIT] = bc_perr;
        r[bridge_window_pkg::BC_SERR_BIT] = bc_serr;
        r[bridge_window_pkg::BC_ISA_BIT] = bc_isa;
      end
      default: begin
        r = 32'h0000_0000;
      end
    endcase
    return r;
  endfunction

  // ****************************************
  // write selection
  // ****************************************
  // the load port wins a same-cycle collision; the cfg write of that cycle is dropped
  logic wr_any;
  logic wr_ld;
  logic [7:0] wr_off;
  logic [31:0] wr_val;
  logic [31:0] w1c_mask;

  always_comb begin
    wr_ld = load.wr;
    wr_any = load.wr | cfg.wr;
    wr_off = load.wr ? load.addr : cfg.addr;
    wr_val = load.wr ? load.data : merge_bytes(read_word(cfg.addr), cfg.wdata, cfg.be);
    w1c_mask = merge_bytes(32'h0000_0000, cfg.wdata, cfg.be);
  end

  logic sec_wr;
  assign sec_wr = wr_any && (wr_off == bridge_window_pkg::OFF_SEC_IO);

  // ****************************************
  // secondary status flags
  // ****************************************
  logic set_mdpe;
  logic set_rse;
  logic set_dpe;
  assign set_mdpe = bc_perr & (sec_ev.poison_cpl | sec_ev.poison_wr_fwd);
  assign set_rse = sec_ev.err_fatal_nf;
  assign set_dpe = sec_ev.poison_rx;

  // a set arriving with a clear wins, so no event is lost
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      sec_mdpe <= 1'b0;
      sec_rse <= 1'b0;
      sec_dpe <= 1'b0;
    end else begin
      if (sec_wr && wr_ld) begin
        sec_mdpe <= wr_val[bridge_window_pkg::SEC_MDPE_BIT] | set_mdpe;
        sec_rse <= wr_val[bridge_window_pkg::SEC_RSE_BIT] | set_rse;
        sec_dpe <= wr_val[bridge_window_pkg::SEC_DPE_BIT] | set_dpe;
      end else if (sec_wr) begin
        sec_mdpe <= set_mdpe | (sec_mdpe & ~w1c_mask[bridge_window_pkg::SEC_MDPE_BIT]);
        sec_rse <= set_rse | (sec_rse & ~w1c_mask[bridge_window_pkg::SEC_RSE_BIT]);
        sec_dpe <= set_dpe | (sec_dpe & ~w1c_mask[bridge_window_pkg::SEC_DPE_BIT]);
      end else begin
        sec_mdpe <= sec_mdpe | set_mdpe;
        sec_rse <= sec_rse | set_rse;
        sec_dpe <= sec_dpe | set_dpe;
      end
    end
  end

  // ****************************************
  // window registers
  // ****************************************
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      io_base <= bridge_window_pkg::IO_BASE_RST;
      io_lim <= bridge_window_pkg::IO_LIM_RST;
      mem_base <= bridge_window_pkg::MEM_BASE_RST;
      mem_lim <= bridge_window_pkg::MEM_LIM_RST;
      pref_window_low_bound <= bridge_window_pkg::MEM_BASE_RST;
      pref_window_high_bound <= bridge_window_pkg::MEM_LIM_RST;
      io_up_base <= 16'h0000;
      io_up_lim <= 16'h0000;
    end else if (wr_any) begin
      case (wr_off)
        bridge_window_pkg::OFF_SEC_IO: begin
          io_base <= wr_val[7:4];
          io_lim <= wr_val[15:12];
        end
        bridge_window_pkg::OFF_MEM_WIN: begin
          mem_base <= wr_val[15:4];
          mem_lim <= wr_val[31:20];
        end
        bridge_window_pkg::OFF_PREF_WIN: begin
          pref_window_low_bound <= wr_val[15:4];
          pref_window_high_bound <= wr_val[31:20];
        end
        bridge_window_pkg::OFF_IO_UPPER: begin
          // capability fields are fixed at 32-bit, so both halves are writable
          io_up_base <= wr_val[15:0];
          io_up_lim <= wr_val[31:16];
        end
        default: begin
        end
      endcase
    end
  end

  // ****************************************
  // prefetch capability and upper words
  // ****************************************
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      pcap_base <= 1'b1;
      pcap_lim <= 1'b1;
    end else if (wr_ld && wr_off == bridge_window_pkg::OFF_PREF_WIN) begin
      pcap_base <= wr_val[bridge_window_pkg::PCAP_BASE_BIT];
      pcap_lim <= wr_val[bridge_window_pkg::PCAP_LIM_BIT];
    end
  end

  // a loader that ignores the read-only state is simply not heard
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      pref_low_bound_upper_word <= 32'h0000_0000;
      pref_high_bound_upper_word <= 32'h0000_0000;
    end else if (wr_any) begin
      if (wr_off == bridge_window_pkg::OFF_PREF_UP_BASE && pcap_base) begin
        pref_low_bound_upper_word <= wr_val;
      end
      if (wr_off == bridge_window_pkg::OFF_PREF_UP_LIM && pcap_lim) begin
        pref_high_bound_upper_word <= wr_val;
      end
    end
  end

  // ****************************************
  // capability pointer, interrupt bytes, bridge control
  // ****************************************
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      cap_ptr <= bridge_window_pkg::CAP_PTR_RST;
    end else if (wr_ld && wr_off == bridge_window_pkg::OFF_CAP_PTR) begin
      cap_ptr <= wr_val[7:0];
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      int_line <= bridge_window_pkg::INT_LINE_RST;
      int_pin_a <= bridge_window_pkg::INT_PIN_RST[0];
      bc_perr <= 1'b0;
      bc_serr <= 1'b0;
      bc_isa <= 1'b0;
    end else if (wr_any && wr_off == bridge_window_pkg::OFF_BRIDGE_CTRL) begin
      int_line <= wr_val[7:0];
      if (wr_ld) begin
        // only codes 00h and 01h exist; any other load value keeps bit 0
        int_pin_a <= wr_val[8];
      end
      bc_perr <= wr_val[bridge_window_pkg::BC_PERR_BIT];
      bc_serr <= wr_val[bridge_window_pkg::BC_SERR_BIT];
      bc_isa <= wr_val[bridge_window_pkg::BC_ISA_BIT];
    end
  end

  // ****************************************
  // read port
  // ****************************************
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      cfg_rdata <= 32'h0000_0000;
      cfg_rvalid <= 1'b0;
      rd_off <= 8'h00;
    end else begin
      cfg_rvalid <= cfg.rd;
      if (cfg.rd) begin
        cfg_rdata <= read_word(cfg.addr);
        rd_off <= cfg.addr;
      end
    end
  end

  // ****************************************
  // error message forwarding
  // ****************************************
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      err_fwd_up <= 1'b0;
      sig_serr_set <= 1'b0;
    end else begin
      err_fwd_up <= bc_serr & (sec_ev.err_fatal_nf | sec_ev.err_cor);
      sig_serr_set <= bc_serr & cmd_serr_en & sec_ev.err_fatal_nf;
    end
  end

  // ****************************************
  // address decode
  // ****************************************
  logic [63:0] mem_lo;
  logic [63:0] mem_hi;
  logic [63:0] pref_lo;
  logic [63:0] pref_hi;
  logic [63:0] io_lo;
  logic [63:0] io_hi;
  logic isa_hole;
  logic sec_in_mem;
  logic sec_in_pref;

  always_comb begin
    mem_lo = {32'h0000_0000, mem_base, 20'h00000};
    mem_hi = {32'h0000_0000, mem_lim, bridge_window_pkg::MEM_LOW_ONES};
    pref_lo = {(pcap_base ? pref_low_bound_upper_word : 32'h0000_0000),
               pref_window_low_bound, 20'h00000};
    pref_hi = {(pcap_lim ? pref_high_bound_upper_word : 32'h0000_0000),
               pref_window_high_bound, bridge_window_pkg::MEM_LOW_ONES};
    io_lo = {32'h0000_0000, io_up_base, io_base, 12'h000};
    io_hi = {32'h0000_0000, io_up_lim, io_lim, bridge_window_pkg::IO_LOW_ONES};
    // upper 768 bytes of each 1 KB block below 64 KB are ISA aliases
    isa_hole = bc_isa && (pri_addr[63:16] == 48'h0) && (pri_addr[9:8] != 2'b00);
    pri_mem_hit = !pri_io && (in_window(pri_addr, mem_lo, mem_hi)
                              || in_window(pri_addr, pref_lo, pref_hi));
    pri_io_hit = pri_io && in_window(pri_addr, io_lo, io_hi) && !isa_hole;
    sec_in_mem = in_window(sec_addr, mem_lo, mem_hi);
    sec_in_pref = in_window(sec_addr, pref_lo, pref_hi);
    sec_mem_up = !sec_io && !sec_in_mem && !sec_in_pref;
    sec_io_up = sec_io && !in_window(sec_addr, io_lo, io_hi);
  end

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);

  a_mdpe_set_on_poison:
    assert property (bc_perr && (sec_ev.poison_cpl || sec_ev.poison_wr_fwd) |=> sec_mdpe)
      else $error("parity flag not set on poisoned traffic");

  a_mdpe_held_off:
    assert property (!bc_perr && !sec_mdpe && !(sec_wr && wr_ld) |=> !sec_mdpe)
      else $error("parity flag set while response disabled");

  a_rse_set_on_msg:
    assert property (sec_ev.err_fatal_nf |=> sec_rse [*2] or (sec_rse ##1 1'b1))
      else $error("received system error flag missed");

  a_dpe_set_always:
    assert property (sec_ev.poison_rx |=> sec_dpe)
      else $error("detected parity flag missed");

  a_abort_bits_zero:
    assert property (cfg_rvalid && rd_off == bridge_window_pkg::OFF_SEC_IO
                     |-> cfg_rdata[29:27] == 3'b000)
      else $error("abort status bits not zero");

  a_mem_hit_valid:
    assert property (pri_mem_hit && !in_window(pri_addr, pref_lo, pref_hi)
                     |-> mem_base <= mem_lim && pri_addr[31:20] >= mem_base)
      else $error("memory forwarded outside window");

  a_up_excludes_down:
    assert property (sec_addr == pri_addr && !sec_io && !pri_io |-> !(sec_mem_up && pri_mem_hit))
      else $error("address claimed in both directions");

  a_upper_base_ro:
    assert property (cfg.rd && cfg.addr == bridge_window_pkg::OFF_PREF_UP_BASE && !pcap_base
                     |=> cfg_rvalid && cfg_rdata == 32'h0000_0000)
      else $error("upper base not zero when read-only");

  a_cap_ptr_read:
    assert property (cfg.rd && cfg.addr == bridge_window_pkg::OFF_CAP_PTR
                     |=> cfg_rdata[31:8] == 24'h000000 && cfg_rdata[7:0] == $past(cap_ptr))
      else $error("capability pointer read wrong");

  a_rom_reads_zero:
    assert property (cfg_rvalid && rd_off == bridge_window_pkg::OFF_ROM_BASE
                     |-> cfg_rdata == 32'h0000_0000)
      else $error("expansion rom register not zero");

  a_err_forward_gate:
    assert property ((sec_ev.err_fatal_nf || sec_ev.err_cor) ##1 err_fwd_up |-> $past(bc_serr))
      else $error("error forwarded while gated off");

  a_isa_hole_blocks:
    assert property (pri_io && bc_isa && pri_addr[63:16] == 48'h0 && pri_addr[9:8] != 2'b00
                     |-> !pri_io_hit)
      else $error("isa alias forwarded downstream");

  a_io_inverted_up:
    assert property (sec_io && io_lo > io_hi |-> sec_io_up && !(pri_io && pri_io_hit))
      else $error("inverted io window mishandled");
endmodule

/* File: verif/downstream_dev_model.sv */
// Purpose: downstream link device model that raises secondary-side events
// Assumes: every event is a one-cycle pulse taken on the rising edge
// Notes: kind 0 poisoned completion, 1 poisoned write forwarded, 2 poisoned tlp
//   received, 3 fatal or nonfatal message, 4 correctable message
`timescale 1ns/1ps
module downstream_dev_model (
  input wire logic core_clk,
  output bridge_window_pkg::sec_event_t sec_ev
);
  initial sec_ev = '0;
  // the idle edge after each pulse keeps two calls from merging
  task automatic send(input int kind);
    @(posedge core_clk);
    sec_ev <= bridge_window_pkg::sec_event_t'(5'h10 >> kind);
    @(posedge core_clk);
    sec_ev <= '0;
  endtask
endmodule

/* File: verif/tb_bridge_window_decode_regs.sv */
// Purpose: self-checking bench for the bridge window and status registers
// Assumes: reads answer one cycle after they are taken
// Notes: read results are compared from a queue by a separate watcher
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin checks++; if ((got) !== (ex)) begin errors++; \
  $display("CHECK FAILED %s exp %h got %h", nm, ex, got); end end
module tb_bridge_window_decode_regs;
  logic core_clk;
  logic reset_n;
  bridge_window_pkg::cfg_req_t cfg;
  bridge_window_pkg::load_req_t load;
  bridge_window_pkg::sec_event_t sec_ev;
  logic cmd_serr_en, pri_io, sec_io, pri_mem_hit, pri_io_hit, sec_mem_up, sec_io_up;
  logic cfg_rvalid, err_fwd_up, sig_serr_set, hit;
  logic [63:0] pri_addr, sec_addr;
  logic [31:0] cfg_rdata, seed, r, exp_r;
  logic [31:0] exp_q[$];
  int errors, checks, cycles;
  logic [7:0] offs [10] = '{8'h1c, 8'h20, 8'h24, 8'h28, 8'h2c, 8'h30, 8'h34, 8'h38,
    8'h3c, 8'h40};
  logic [31:0] rstv [10] = '{32'h0000_01f1, 32'h0000_fff0, 32'h0001_fff1, 32'h0, 32'h0,
    32'h0, 32'h0000_0040, 32'h0, 32'h0000_0100, 32'h0};

  bridge_window_decode_regs i_bridge_window_decode_regs (.core_clk(core_clk),
    .reset_n(reset_n), .cfg(cfg), .cfg_rdata(cfg_rdata), .cfg_rvalid(cfg_rvalid),
    .load(load), .sec_ev(sec_ev), .cmd_serr_en(cmd_serr_en), .pri_addr(pri_addr),
    .pri_io(pri_io), .pri_mem_hit(pri_mem_hit), .pri_io_hit(pri_io_hit),
    .sec_addr(sec_addr), .sec_io(sec_io), .sec_mem_up(sec_mem_up),
    .sec_io_up(sec_io_up), .err_fwd_up(err_fwd_up), .sig_serr_set(sig_serr_set));
  downstream_dev_model i_downstream_dev_model (.core_clk(core_clk), .sec_ev(sec_ev));

  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  // ****************************************
  // bus tasks
  // ****************************************
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] be);
    @(posedge core_clk);
    cfg.wr <= 1'b1;
    cfg.addr <= a;
    cfg.be <= be;
    cfg.wdata <= d;
    @(posedge core_clk);
    cfg.wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge core_clk);
    cfg.rd <= 1'b1;
    cfg.addr <= a;
    exp_q.push_back(e);
    @(posedge core_clk);
    cfg.rd <= 1'b0;
  endtask
  task automatic ld(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    load.wr <= 1'b1;
    load.addr <= a;
    load.data <= d;
    @(posedge core_clk);
    load.wr <= 1'b0;
  endtask
  // up given as x skips the upstream compare where the reading is open
  task automatic dec(input logic io, input logic [63:0] a, input logic dn, input logic up);
    @(posedge core_clk);
    pri_io <= io;
    sec_io <= io;
    pri_addr <= a;
    sec_addr <= a;
    #1;
    `CHK("down_hit", dn, io ? pri_io_hit : pri_mem_hit)
    if (up !== 1'bx) `CHK("up_fwd", up, io ? sec_io_up : sec_mem_up)
  endtask
  task automatic ev(input int k, input logic fwd, input logic serr);
    i_downstream_dev_model.send(k);
    #1;
    `CHK("err_fwd_up", fwd, err_fwd_up)
    `CHK("sig_serr_set", serr, sig_serr_set)
  endtask
  task automatic test_done();
    $display("errors %0d checks %0d", errors, checks);
    if (errors == 0 && checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // ****************************************
  // read watcher and timeout
  // ****************************************
  // the watcher keeps its own expected word so the stimulus loop never shares one
  always @(posedge core_clk) begin
    cycles++;
    if (cfg_rvalid === 1'b1) begin
      if (exp_q.size() == 0) begin
        errors++;
        $display("CHECK FAILED rdata exp none got %h", cfg_rdata);
      end else begin
        exp_r = exp_q.pop_front();
        `CHK("rdata", exp_r, cfg_rdata)
      end
    end
    if (cycles == 5000) begin
      errors++;
      test_done();
    end
  end

  initial begin
    seed = 32'hd8368ecf;
    cfg = '0;
    load = '0;
    pri_addr = '0;
    sec_addr = '0;
    pri_io = 1'b0;
    sec_io = 1'b0;
    cmd_serr_en = 1'b0;
    reset_n = 1'b0;
    repeat (4) @(posedge core_clk);
    reset_n <= 1'b1;
    foreach (offs[i]) rd(offs[i], rstv[i]);
    dec(1'b0, 64'h0, 1'b0, 1'b1);
    dec(1'b1, 64'h0, 1'b0, 1'b1);
    // ****************************************
    // read-only and reserved places, then writable scratch and upper words
    // ****************************************
    wr(8'h34, '1, 4'hf);
    wr(8'h38, '1, 4'hf);
    wr(8'h24, 32'h0, 4'hf);
    wr(8'h1c, 32'h3800_0000, 4'h8);
    wr(8'h40, '1, 4'hf);
    rd(8'h34, 32'h0000_0040);
    rd(8'h38, 32'h0);
    rd(8'h24, 32'h0001_0001);
    rd(8'h1c, 32'h0000_01f1);
    rd(8'h40, 32'h0);
    wr(8'h3c, '1, 4'h1);
    wr(8'h3c, 32'h0, 4'h2);
    rd(8'h3c, 32'h0000_01ff);
    wr(8'h28, 32'ha5a5_5a5a, 4'hf);
    wr(8'h2c, 32'h5a5a_a5a5, 4'hf);
    wr(8'h30, 32'h1234_5678, 4'hf);
    rd(8'h28, 32'ha5a5_5a5a);
    rd(8'h2c, 32'h5a5a_a5a5);
    rd(8'h30, 32'h1234_5678);
    // ****************************************
    // secondary status events
    // ****************************************
    @(posedge core_clk);
    cmd_serr_en <= 1'b1;
    ev(0, 1'b0, 1'b0);
    ev(1, 1'b0, 1'b0);
    rd(8'h1c, 32'h0000_01f1);
    ev(2, 1'b0, 1'b0);
    ev(3, 1'b0, 1'b0);
    rd(8'h1c, 32'hc000_01f1);
    wr(8'h1c, 32'h4000_0000, 4'h8);
    rd(8'h1c, 32'h8000_01f1);
    wr(8'h1c, 32'h8000_0000, 4'h8);
    wr(8'h3c, 32'h0003_0000, 4'h4);
    rd(8'h3c, 32'h0003_01ff);
    ev(0, 1'b0, 1'b0);
    rd(8'h1c, 32'h0100_01f1);
    wr(8'h1c, 32'h0100_0000, 4'h8);
    ev(1, 1'b0, 1'b0);
    rd(8'h1c, 32'h0100_01f1);
    ev(3, 1'b1, 1'b1);
    ev(4, 1'b1, 1'b0);
    @(posedge core_clk);
    cmd_serr_en <= 1'b0;
    ev(3, 1'b1, 1'b0);
    wr(8'h1c, 32'hff00_0000, 4'h8);
    rd(8'h1c, 32'h0000_01f1);
    // ****************************************
    // memory windows
    // ****************************************
    wr(8'h20, 32'h1ff0_1000, 4'hf);
    rd(8'h20, 32'h1ff0_1000);
    dec(1'b0, 64'h1000_0000, 1'b1, 1'b0);
    dec(1'b0, 64'h1fff_ffff, 1'b1, 1'b0);
    dec(1'b0, 64'h0fff_ffff, 1'b0, 1'b1);
    dec(1'b0, 64'h2000_0000, 1'b0, 1'b1);
    repeat (16) begin
      r = $random(seed) & 32'h3fff_ffff;
      hit = (r >= 32'h1000_0000) && (r <= 32'h1fff_ffff);
      dec(1'b0, {32'h0, r}, hit, !hit);
    end
    wr(8'h24, 32'h3ff0_3000, 4'hf);
    wr(8'h28, 32'h1, 4'hf);
    wr(8'h2c, 32'h1, 4'hf);
    rd(8'h24, 32'h3ff1_3001);
    dec(1'b0, 64'h1_3000_0000, 1'b1, 1'b0);
    dec(1'b0, 64'h1_3fff_ffff, 1'b1, 1'b0);
    dec(1'b0, 64'h3000_0000, 1'b0, 1'b1);
    dec(1'b0, 64'h1_4000_0000, 1'b0, 1'b1);
    ld(8'h24, 32'h3ff0_3000);
    ld(8'h28, 32'h0);
    ld(8'h2c, 32'h0);
    wr(8'h28, '1, 4'hf);
    wr(8'h2c, '1, 4'hf);
    rd(8'h24, 32'h3ff0_3000);
    rd(8'h28, 32'h0);
    rd(8'h2c, 32'h0);
    dec(1'b0, 64'h3000_0000, 1'b1, 1'b0);
    wr(8'h20, 32'h1000_1ff0, 4'hf);
    dec(1'b0, 64'h1800_0000, 1'b0, 1'b1);
    // ****************************************
    // io window and isa holes
    // ****************************************
    wr(8'h30, 32'h0, 4'hf);
    wr(8'h1c, 32'h0000_f000, 4'h3);
    rd(8'h1c, 32'h0000_f101);
    dec(1'b1, 64'h0100, 1'b1, 1'b0);
    wr(8'h3c, 32'h0004_0000, 4'h4);
    dec(1'b1, 64'h0100, 1'b0, 1'bx);
    dec(1'b1, 64'h0300, 1'b0, 1'bx);
    dec(1'b1, 64'h04ff, 1'b1, 1'b0);
    dec(1'b1, 64'h1_0000, 1'b0, 1'b1);
    wr(8'h30, 32'h0001_0001, 4'hf);
    dec(1'b1, 64'h1_0100, 1'b1, 1'b0);
    wr(8'h1c, 32'h0000_00f0, 4'h3);
    dec(1'b1, 64'h1_f000, 1'b0, 1'b1);
    // ****************************************
    // reset in mid-run
    // ****************************************
    @(posedge core_clk);
    reset_n <= 1'b0;
    @(posedge core_clk);
    reset_n <= 1'b1;
    rd(8'h20, 32'h0000_fff0);
    rd(8'h24, 32'h0001_fff1);
    rd(8'h30, 32'h0);
    // ****************************************
    // initialization loads after reset
    // ****************************************
    ld(8'h3c, 32'h0000_02a5);
    rd(8'h3c, 32'h0000_00a5);
    ld(8'h34, 32'h0000_0050);
    rd(8'h34, 32'h0000_0050);
    ld(8'h1c, 32'h4000_0000);
    rd(8'h1c, 32'h4000_0101);
    repeat (3) @(posedge core_clk);
    `CHK("queue", 0, exp_q.size())
    test_done();
  end
endmodule
